// file: verilog/sws_defs.vh
`ifndef SWS_DEFS_VH
`define SWS_DEFS_VH
// Host command codes
`define SWS_CMD_BLOCK_READ 8'h50
`define SWS_CMD_SEARCH 8'h11
`define SWS_CMD_FULL_SEQ 8'h57
// Result bytes
`define SWS_RES_OK 8'hAA
`define SWS_RES_BAD_PARAM 8'h77
`define SWS_RES_BR_COMM 8'h22
`define SWS_RES_NO_PRESENCE 8'h33
`define SWS_RES_NOT_FOUND 8'h00
`define SWS_RES_FS_COMM 8'h00
`define SWS_RES_FS_HW 8'h22
`define SWS_RES_FS_SEQ 8'h33
`define SWS_RES_FS_DISABLED 8'h88
// Bytes sent on the line
`define SWS_NODE_SELECT 8'h55
`define SWS_CMD_START 8'h66
`define SWS_RELEASE 8'hAA
// Limits and lengths
`define SWS_MAX_FETCH 8'h7E
`define SWS_MAX_PAYLOAD 8'h74
`define SWS_MAX_REPLY 8'h7C
`define SWS_LAST_BIT 6'h3F
`define SWS_ID_LAST_BYTE 8'h07
`define SWS_FS_START_IDX 8'h08
`define SWS_FS_LEN_IDX 8'h09
`define SWS_BR_REQ_LEN 8'h01
`define SWS_SR_REQ_LEN 8'h02
`define SWS_FS_HDR_LEN 8'h09
`define SWS_SR_OK_LEN 8'h0A
`define SWS_FAIL_LEN 8'h01
`define SWS_SR_FLAG_IDX 8'h08
`define SWS_HDR_LAST 8'h02
// Search parameter bits
`define SWS_P_LINE_RESET 0
`define SWS_P_SKIP_PRES 1
`define SWS_P_RESTART 2
`define SWS_P_UPPER 7:3
// Line primitive operations
`define SWS_OP_RESET 2'h0
`define SWS_OP_WRITE 2'h1
`define SWS_OP_READ 2'h2
`define SWS_OP_TRIPLET 2'h3
// CRC16, reflected form
`define SWS_CRC_POLY 16'hA001
`define SWS_CRC_INIT 16'h0000
// Buffer positions
`define SWS_RSP_LEN_POS 7'h00
`define SWS_RSP_RES_POS 7'h01
`define SWS_RSP_DATA_POS 7'h02
`define SWS_RSP_REPLY_POS 7'h03
`define SWS_REQ_ID_POS 7'h02
// APB byte addresses
`define SWS_A_CMD 8'h00
`define SWS_A_REQ_PTR 8'h04
`define SWS_A_REQ_DATA 8'h08
`define SWS_A_RSP_PTR 8'h0C
`define SWS_A_RSP_DATA 8'h10
`define SWS_A_STATUS 8'h14
`define SWS_A_CONFIG 8'h18
// Config: bit 0 overdrive, bit 1 enable
`define SWS_CFG_RESET 2'h2
`define SWS_CFG_OVD 0
`define SWS_CFG_EN 1
// Timing
`define SWS_SPU_STEP_MS 2
`define SWS_CLK_KHZ 25000
`endif

// file: verilog/sws_byte_buf.v
module sws_byte_buf #(
	parameter DEPTH = 128,
	parameter AW = 7
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [7:0] wdata,
	input wire [AW-1:0] raddr,
	output wire [7:0] rdata
);
	// Flip-flop storage, no reset: contents only matter once written
	reg [7:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule

// file: verilog/sws_engine.v
`include "sws_defs.vh"
module sws_engine #(
	parameter DEPTH = 128,
	parameter AW = 7,
	parameter STEP_W = 16,
	parameter HOLD_STEP_CYCLES = `SWS_SPU_STEP_MS * `SWS_CLK_KHZ
) (
	input wire REF_CLK,
	input wire RST_B,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output reg PSLVERR,
	output reg LINE_REQ,
	output reg [1:0] LINE_OP,
	output reg [7:0] LINE_TX,
	input wire LINE_DONE,
	input wire [7:0] LINE_RX,
	input wire LINE_PRESENT,
	input wire LINE_FAULT,
	output wire LINE_OVERDRIVE,
	output reg STRONG_PULLUP
);
	localparam S_IDLE = 5'h00, S_LD = 5'h01, S_WAIT = 5'h02, S_FIN0 = 5'h03;
	localparam S_FIN1 = 5'h04, S_BR_GO = 5'h05, S_BR_DAT = 5'h06;
	localparam S_SR_GO = 5'h07, S_SR_PRES = 5'h08, S_SR_CMD = 5'h09;
	localparam S_SR_BIT = 5'h0A, S_SR_CHK = 5'h0B, S_SR_END = 5'h0C;
	localparam S_SR_OUT = 5'h0D, S_FS_GO = 5'h0E, S_FS_SEL = 5'h0F;
	localparam S_FS_TX = 5'h10, S_FS_RXC = 5'h11, S_CRC = 5'h12;
	localparam S_FS_HOLD = 5'h13, S_FS_DUM = 5'h14, S_FS_RLEN = 5'h15;
	localparam S_FS_RDAT = 5'h16;
	localparam integer STEP_LAST_FULL = HOLD_STEP_CYCLES - 1;
	localparam [STEP_W-1:0] STEP_LAST = STEP_LAST_FULL[STEP_W-1:0];

	reg [4:0] state, ret;
	reg [7:0] cmd, hdr0, hdr1, hdr2, idx, rcap, rlen, crc_lo;
	reg [7:0] rsp_len, res_code, err_code, unit_cnt;
	reg [15:0] crc;
	reg [63:0] node_id;
	reg [6:0] last_disc, last_zero;
	reg [5:0] bitn;
	reg [STEP_W-1:0] step_cnt;
	reg pres, sub, phase2, no_more, busy;
	reg rsp_we;
	reg [AW-1:0] rsp_wa;
	reg [7:0] rsp_wd;
	reg start;
	reg [7:0] start_code;
	reg [AW-1:0] req_ptr, rsp_ptr;
	reg [1:0] cfg;
	reg req_we;
	reg [AW-1:0] req_wa;
	reg [7:0] req_wd;
	wire [AW-1:0] req_ra;
	wire [7:0] req_rd, rsp_rd;
	wire [7:0] plen;
	wire [7:0] fs_last;
	wire [7:0] fs_byte;
	wire [6:0] pos;
	wire cand;
	wire id_bit, cmp_bit;
	wire apb_setup, apb_acc;

	function [15:0] crc16_byte;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] x;
		begin
			x = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1) begin
				x = x[0] ? ((x >> 1) ^ `SWS_CRC_POLY) : (x >> 1);
			end
			crc16_byte = x;
		end
	endfunction

	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a == `SWS_A_CMD) || (a == `SWS_A_REQ_PTR) ||
				(a == `SWS_A_REQ_DATA) || (a == `SWS_A_RSP_PTR) ||
				(a == `SWS_A_RSP_DATA) || (a == `SWS_A_STATUS) ||
				(a == `SWS_A_CONFIG);
		end
	endfunction

	sws_byte_buf #(.DEPTH(DEPTH), .AW(AW)) u_req (
		.clk(REF_CLK),
		.we(req_we),
		.waddr(req_wa),
		.wdata(req_wd),
		.raddr(req_ra),
		.rdata(req_rd)
	);

	sws_byte_buf #(.DEPTH(DEPTH), .AW(AW)) u_rsp (
		.clk(REF_CLK),
		.we(rsp_we),
		.waddr(rsp_wa),
		.wdata(rsp_wd),
		.raddr(rsp_ptr),
		.rdata(rsp_rd)
	);

	assign apb_setup = PSEL & ~PENABLE;
	assign apb_acc = PSEL & PENABLE;
	// Zero wait states: read data is fetched in the setup cycle
	assign PREADY = 1'b1;
	assign LINE_OVERDRIVE = cfg[`SWS_CFG_OVD];

	assign req_ra = (state == S_FS_TX && idx < `SWS_FS_START_IDX) ?
		(idx[AW-1:0] + `SWS_REQ_ID_POS) : idx[AW-1:0];
	assign plen = hdr0 - `SWS_FS_HDR_LEN;
	assign fs_last = `SWS_FS_LEN_IDX + plen;
	// Id, start code, length, payload; the select byte goes out before, from S_FS_SEL
	assign fs_byte = (idx == `SWS_FS_START_IDX) ? `SWS_CMD_START :
		(idx == `SWS_FS_LEN_IDX) ? plen : req_rd;
	assign pos = {1'b0, bitn} + 7'h01;
	assign cand = (pos < last_disc) ? node_id[bitn] : (pos == last_disc);
	assign id_bit = rcap[0];
	assign cmp_bit = rcap[1];

	always @(posedge REF_CLK) begin
		if (!RST_B) begin
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
			start <= 1'b0;
			start_code <= 8'h00;
			req_ptr <= {AW{1'b0}};
			rsp_ptr <= {AW{1'b0}};
			cfg <= `SWS_CFG_RESET;
			req_we <= 1'b0;
			req_wa <= {AW{1'b0}};
			req_wd <= 8'h00;
		end else begin
			start <= 1'b0;
			req_we <= 1'b0;
			if (apb_setup) begin
				PSLVERR <= ~addr_mapped(PADDR);
				if (PWRITE) begin
					PRDATA <= 32'h00000000;
				end else if (PADDR == `SWS_A_REQ_PTR) begin
					PRDATA <= {{(32-AW){1'b0}}, req_ptr};
				end else if (PADDR == `SWS_A_RSP_PTR) begin
					PRDATA <= {{(32-AW){1'b0}}, rsp_ptr};
				end else if (PADDR == `SWS_A_RSP_DATA) begin
					PRDATA <= {24'h000000, rsp_rd};
				end else if (PADDR == `SWS_A_STATUS) begin
					PRDATA <= {8'h00, rsp_len, res_code, 7'h00, busy | start};
				end else if (PADDR == `SWS_A_CONFIG) begin
					PRDATA <= {30'h00000000, cfg};
				end else begin
					PRDATA <= 32'h00000000;
				end
			end
			if (apb_acc && PWRITE) begin
				// Command and request data writes are dropped while a command runs
				if (PADDR == `SWS_A_CMD && !busy) begin
					start <= 1'b1;
					start_code <= PWDATA[7:0];
				end else if (PADDR == `SWS_A_REQ_PTR) begin
					req_ptr <= PWDATA[AW-1:0];
				end else if (PADDR == `SWS_A_REQ_DATA && !busy) begin
					req_we <= 1'b1;
					req_wa <= req_ptr;
					req_wd <= PWDATA[7:0];
					req_ptr <= req_ptr + 1'b1;
				end else if (PADDR == `SWS_A_RSP_PTR) begin
					rsp_ptr <= PWDATA[AW-1:0];
				end else if (PADDR == `SWS_A_CONFIG) begin
					cfg <= PWDATA[1:0];
				end
			end else if (apb_acc && PADDR == `SWS_A_RSP_DATA) begin
				rsp_ptr <= rsp_ptr + 1'b1;
			end
		end
	end

	task issue;
		input [1:0] op;
		input [7:0] tx;
		input [4:0] back;
		begin
			LINE_REQ <= 1'b1;
			LINE_OP <= op;
			LINE_TX <= tx;
			ret <= back;
			state <= S_WAIT;
		end
	endtask

	task finish;
		input [7:0] len;
		input [7:0] code;
		begin
			rsp_len <= len;
			res_code <= code;
			state <= S_FIN0;
		end
	endtask

	task put_rsp;
		input [AW-1:0] a;
		input [7:0] d;
		begin
			rsp_we <= 1'b1;
			rsp_wa <= a;
			rsp_wd <= d;
		end
	endtask

	always @(posedge REF_CLK) begin
		if (!RST_B) begin
			state <= S_IDLE;
			ret <= S_IDLE;
			cmd <= 8'h00;
			hdr0 <= 8'h00;
			hdr1 <= 8'h00;
			hdr2 <= 8'h00;
			idx <= 8'h00;
			rcap <= 8'h00;
			rlen <= 8'h00;
			crc_lo <= 8'h00;
			rsp_len <= 8'h00;
			res_code <= 8'h00;
			err_code <= 8'h00;
			unit_cnt <= 8'h00;
			crc <= `SWS_CRC_INIT;
			node_id <= 64'h0000000000000000;
			last_disc <= 7'h00;
			last_zero <= 7'h00;
			bitn <= 6'h00;
			step_cnt <= {STEP_W{1'b0}};
			pres <= 1'b0;
			sub <= 1'b0;
			phase2 <= 1'b0;
			no_more <= 1'b0;
			busy <= 1'b0;
			rsp_we <= 1'b0;
			rsp_wa <= {AW{1'b0}};
			rsp_wd <= 8'h00;
			LINE_REQ <= 1'b0;
			LINE_OP <= `SWS_OP_RESET;
			LINE_TX <= 8'h00;
			STRONG_PULLUP <= 1'b0;
		end else begin
			LINE_REQ <= 1'b0;
			rsp_we <= 1'b0;
			case (state)
			S_IDLE: begin
				if (start) begin
					busy <= 1'b1;
					cmd <= start_code;
					idx <= 8'h00;
					state <= S_LD;
				end
			end
			S_LD: begin
				idx <= idx + 8'h01;
				if (idx == 8'h00) begin
					hdr0 <= req_rd;
				end else if (idx == 8'h01) begin
					hdr1 <= req_rd;
				end else begin
					hdr2 <= req_rd;
				end
				if (idx == `SWS_HDR_LAST) begin
					if (cmd == `SWS_CMD_BLOCK_READ) begin
						err_code <= `SWS_RES_BR_COMM;
						state <= S_BR_GO;
					end else if (cmd == `SWS_CMD_SEARCH) begin
						err_code <= `SWS_RES_NOT_FOUND;
						state <= S_SR_GO;
					end else if (cmd == `SWS_CMD_FULL_SEQ) begin
						err_code <= `SWS_RES_FS_HW;
						state <= S_FS_GO;
					end else begin
						finish(`SWS_FAIL_LEN, `SWS_RES_BAD_PARAM);
					end
				end
			end
			S_WAIT: begin
				if (LINE_DONE) begin
					rcap <= LINE_RX;
					pres <= LINE_PRESENT;
					if (LINE_FAULT) begin
						STRONG_PULLUP <= 1'b0;
						finish(`SWS_FAIL_LEN, err_code);
					end else begin
						state <= ret;
					end
				end
			end
			S_FIN0: begin
				put_rsp(`SWS_RSP_LEN_POS, rsp_len);
				state <= S_FIN1;
			end
			S_FIN1: begin
				put_rsp(`SWS_RSP_RES_POS, res_code);
				busy <= 1'b0;
				state <= S_IDLE;
			end
			S_BR_GO: begin
				idx <= 8'h00;
				if (hdr0 != `SWS_BR_REQ_LEN || hdr1 == 8'h00 ||
					hdr1 > `SWS_MAX_FETCH) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_BAD_PARAM);
				end else begin
					issue(`SWS_OP_READ, 8'h00, S_BR_DAT);
				end
			end
			S_BR_DAT: begin
				put_rsp(`SWS_RSP_DATA_POS + idx[AW-1:0], rcap);
				idx <= idx + 8'h01;
				if (idx + 8'h01 == hdr1) begin
					finish(hdr1 + 8'h01, `SWS_RES_OK);
				end else begin
					issue(`SWS_OP_READ, 8'h00, S_BR_DAT);
				end
			end
			S_SR_GO: begin
				if (hdr1[`SWS_P_RESTART]) begin
					last_disc <= 7'h00;
					no_more <= 1'b0;
				end
				if (hdr0 != `SWS_SR_REQ_LEN || hdr1[`SWS_P_UPPER] != 5'h00) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_BAD_PARAM);
				end else if (no_more && !hdr1[`SWS_P_RESTART]) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_NOT_FOUND);
				end else if (hdr1[`SWS_P_LINE_RESET]) begin
					issue(`SWS_OP_RESET, 8'h00, S_SR_PRES);
				end else begin
					state <= S_SR_CMD;
				end
			end
			S_SR_PRES: begin
				if (!pres && !hdr1[`SWS_P_SKIP_PRES]) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_NO_PRESENCE);
				end else begin
					state <= S_SR_CMD;
				end
			end
			S_SR_CMD: begin
				bitn <= 6'h00;
				last_zero <= 7'h00;
				issue(`SWS_OP_WRITE, hdr2, S_SR_BIT);
			end
			S_SR_BIT: begin
				issue(`SWS_OP_TRIPLET, {7'h00, cand}, S_SR_CHK);
			end
			S_SR_CHK: begin
				// Bit and complement decide the path
				if (id_bit && cmp_bit) begin
					last_disc <= 7'h00;
					no_more <= 1'b0;
					finish(`SWS_FAIL_LEN, `SWS_RES_NOT_FOUND);
				end else begin
					node_id[bitn] <= rcap[2];
					if (!id_bit && !cmp_bit && !rcap[2]) begin
						last_zero <= pos;
					end
					bitn <= bitn + 6'h01;
					state <= (bitn == `SWS_LAST_BIT) ? S_SR_END : S_SR_BIT;
				end
			end
			S_SR_END: begin
				last_disc <= last_zero;
				// Final node when no branch remains
				no_more <= (last_zero == 7'h00);
				idx <= 8'h00;
				state <= S_SR_OUT;
			end
			S_SR_OUT: begin
				idx <= idx + 8'h01;
				if (idx == `SWS_SR_FLAG_IDX) begin
					put_rsp(`SWS_RSP_DATA_POS + idx[AW-1:0], {7'h00, no_more});
					finish(`SWS_SR_OK_LEN, `SWS_RES_OK);
				end else begin
					put_rsp(`SWS_RSP_DATA_POS + idx[AW-1:0],
						node_id[idx[2:0]*8 +: 8]);
				end
			end
			S_FS_GO: begin
				idx <= 8'h00;
				phase2 <= 1'b0;
				crc <= `SWS_CRC_INIT;
				if (!cfg[`SWS_CFG_EN]) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_FS_DISABLED);
				end else if (hdr0 <= `SWS_FS_HDR_LEN || plen > `SWS_MAX_PAYLOAD) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_FS_SEQ);
				end else begin
					issue(`SWS_OP_RESET, 8'h00, S_FS_SEL);
				end
			end
			S_FS_SEL: begin
				issue(`SWS_OP_WRITE, `SWS_NODE_SELECT, S_FS_TX);
			end
			S_FS_TX: begin
				idx <= idx + 8'h01;
				if (idx >= `SWS_FS_START_IDX) begin
					crc <= crc16_byte(crc, fs_byte);
				end
				issue(`SWS_OP_WRITE, fs_byte,
					(idx == fs_last) ? S_FS_RXC : S_FS_TX);
			end
			S_FS_RXC: begin
				sub <= 1'b0;
				issue(`SWS_OP_READ, 8'h00, S_CRC);
			end
			S_CRC: begin
				if (!sub) begin
					crc_lo <= rcap;
					sub <= 1'b1;
					issue(`SWS_OP_READ, 8'h00, S_CRC);
				end else if ({rcap, crc_lo} != ~crc) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_FS_COMM);
				end else if (!phase2) begin
					STRONG_PULLUP <= 1'b1;
					unit_cnt <= 8'h00;
					step_cnt <= {STEP_W{1'b0}};
					issue(`SWS_OP_WRITE, `SWS_RELEASE, S_FS_HOLD);
				end else begin
					finish(rlen + 8'h02, `SWS_RES_OK);
				end
			end
			S_FS_HOLD: begin
				if (unit_cnt == hdr1) begin
					STRONG_PULLUP <= 1'b0;
					issue(`SWS_OP_READ, 8'h00, S_FS_DUM);
				end else if (step_cnt == STEP_LAST) begin
					step_cnt <= {STEP_W{1'b0}};
					unit_cnt <= unit_cnt + 8'h01;
				end else begin
					step_cnt <= step_cnt + 1'b1;
				end
			end
			S_FS_DUM: begin
				issue(`SWS_OP_READ, 8'h00, S_FS_RLEN);
			end
			S_FS_RLEN: begin
				rlen <= rcap;
				idx <= 8'h00;
				phase2 <= 1'b1;
				sub <= 1'b0;
				crc <= crc16_byte(`SWS_CRC_INIT, rcap);
				put_rsp(`SWS_RSP_DATA_POS, rcap);
				if (rcap == 8'h00 || rcap > `SWS_MAX_REPLY) begin
					finish(`SWS_FAIL_LEN, `SWS_RES_FS_SEQ);
				end else begin
					issue(`SWS_OP_READ, 8'h00, S_FS_RDAT);
				end
			end
			S_FS_RDAT: begin
				put_rsp(`SWS_RSP_REPLY_POS + idx[AW-1:0], rcap);
				crc <= crc16_byte(crc, rcap);
				idx <= idx + 8'h01;
				issue(`SWS_OP_READ, 8'h00,
					(idx + 8'h01 == rlen) ? S_CRC : S_FS_RDAT);
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// file: verification/sws_engine_monitor.sv
`include "sws_defs.vh"
module sws_engine_monitor (
	input logic REF_CLK,
	input logic RST_B,
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [7:0] PADDR,
	input logic [31:0] PWDATA,
	input logic [31:0] PRDATA,
	input logic PREADY,
	input logic PSLVERR,
	input logic LINE_REQ,
	input logic [1:0] LINE_OP,
	input logic [7:0] LINE_TX,
	input logic LINE_DONE,
	input logic LINE_OVERDRIVE,
	input logic STRONG_PULLUP
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	logic out_q;
	// One line operation in flight
	always @(posedge REF_CLK) begin
		if (!RST_B)
			out_q <= 1'b0;
		else if (LINE_REQ)
			out_q <= 1'b1;
		else if (LINE_DONE)
			out_q <= 1'b0;
	end
	chk_ready_high: assert property (PREADY)
		else $error("pready low");
	chk_req_pulse: assert property (LINE_REQ |=> !LINE_REQ)
		else $error("line request longer than one cycle");
	chk_one_op: assert property (LINE_REQ |-> !out_q)
		else $error("line request while one is open");
	chk_op_stands: assert property (out_q && !LINE_REQ |->
		$stable(LINE_OP) && $stable(LINE_TX))
		else $error("line op changed while open");
	chk_spu_rise: assert property (
		$rose(STRONG_PULLUP) |-> LINE_REQ &&
		LINE_OP == `SWS_OP_WRITE && LINE_TX == `SWS_RELEASE)
		else $error("pullup rose without release write");
	chk_spu_quiet: assert property (
		STRONG_PULLUP && $past(STRONG_PULLUP) |-> !LINE_REQ)
		else $error("line request during pullup hold");
	chk_spu_end: assert property (
		$fell(STRONG_PULLUP) |-> LINE_REQ && LINE_OP == `SWS_OP_READ)
		else $error("pullup fell without dummy read");
	chk_ovd_cfg: assert property (
		PSEL && PENABLE && PWRITE && PADDR == `SWS_A_CONFIG |=>
		LINE_OVERDRIVE == $past(PWDATA[0]))
		else $error("overdrive does not follow config");
	chk_bad_addr: assert property (
		PSEL && PENABLE && PADDR > `SWS_A_CONFIG |-> PSLVERR)
		else $error("no error on unmapped address");
	chk_wr_rdata: assert property (
		PSEL && PENABLE && PWRITE |-> PRDATA == 32'h0)
		else $error("read data not zero on write");
	cover property ($rose(STRONG_PULLUP));
	cover property (LINE_REQ && LINE_OP == `SWS_OP_TRIPLET);
	cover property (PSLVERR && PENABLE);
endmodule
bind sws_engine sws_engine_monitor sws_engine_monitor_inst (
	.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_REQ(LINE_REQ),
	.LINE_OP(LINE_OP), .LINE_TX(LINE_TX), .LINE_DONE(LINE_DONE),
	.LINE_OVERDRIVE(LINE_OVERDRIVE), .STRONG_PULLUP(STRONG_PULLUP));

// file: verification/sws_line_model.sv
`include "sws_defs.vh"
module sws_line_model (
	input wire clk,
	input wire rst_b,
	input wire req,
	input wire [1:0] op,
	input wire [7:0] tx,
	input wire strong_pullup,
	output logic done,
	output logic [7:0] rx,
	output logic present,
	output logic fault
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rd_q[$];
	logic [7:0] wr_q[$];
	logic [63:0] node_id = 64'h0;
	logic pres = 1'b1, flt = 1'b0, busy = 1'b0;
	logic [1:0] cur = 2'h0;
	logic [7:0] ctx = 8'h00;
	logic [5:0] bi = 6'h00;
	int lag = 2, w = 0, spu_cnt = 0;
	initial {done, rx, present, fault} = 11'h0;
	// Idle rx, present and fault toggle so stale values never look valid
	always @(posedge clk) begin
		done <= 1'b0;
		rx <= ~rx;
		present <= ~present;
		fault <= ~fault;
		if (strong_pullup)
			spu_cnt <= spu_cnt + 1;
		if (!rst_b) begin
			busy <= 1'b0;
		end else if (req) begin
			busy <= 1'b1;
			w <= lag;
			cur <= op;
			ctx <= tx;
		end else if (busy && w > 0) begin
			w <= w - 1;
		end else if (busy) begin
			busy <= 1'b0;
			done <= 1'b1;
			fault <= flt;
			present <= pres;
			case (cur)
				`SWS_OP_RESET: bi <= 6'h00;
				`SWS_OP_WRITE: begin
					bi <= 6'h00;
					wr_q.push_back(ctx);
				end
				`SWS_OP_READ: rx <= rd_q.size() ? rd_q.pop_front() : ~rx;
				// single node answers bit, complement, direction
				default: begin
					rx <= {5'h0, node_id[bi], ~node_id[bi], node_id[bi]};
					bi <= bi + 6'h01;
				end
			endcase
		end
	end
endmodule

// file: verification/test_single_wire_search_and_sequence.sv
`include "sws_defs.vh"
module test_single_wire_search_and_sequence;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HS = 20;
	localparam logic [63:0] ID = 64'h8C00_0012_3456_7828;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, st;
	logic pready, pslverr, err, req, done, pres, flt, ovd, strong_pullup;
	logic [1:0] op;
	logic [7:0] tx, rx;
	logic [7:0] q[$];
	logic [7:0] rsp[16];
	int bad_count = 0, comparisons = 0, cyc = 0;
	always #20 clk = ~clk;
	sws_engine #(.HOLD_STEP_CYCLES(HS)) sws_engine_inst (.REF_CLK(clk),
		.RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LINE_REQ(req), .LINE_OP(op), .LINE_TX(tx),
		.LINE_DONE(done), .LINE_RX(rx), .LINE_PRESENT(pres),
		.LINE_FAULT(flt), .LINE_OVERDRIVE(ovd), .STRONG_PULLUP(strong_pullup));
	sws_line_model sws_line_model_inst (.clk(clk), .rst_b(rst_b),
		.req(req), .op(op), .tx(tx), .strong_pullup(strong_pullup), .done(done), .rx(rx),
		.present(pres), .fault(flt));
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			bad_count++;
			give_verdict;
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// host polls busy before reading the answer
	task run(input logic [7:0] c, input logic [7:0] r, input logic [7:0] l);
		int n;
		apb(1, `SWS_A_REQ_PTR, 0);
		foreach (q[i])
			apb(1, `SWS_A_REQ_DATA, {24'h0, q[i]});
		apb(1, `SWS_A_CMD, {24'h0, c});
		n = 0;
		do begin
			apb(0, `SWS_A_STATUS, 0);
			n++;
		end while (rd[0] !== 1'b0 && n < 500);
		chk("busy", rd[0], 1'b0);
		st = rd;
		apb(1, `SWS_A_RSP_PTR, 0);
		for (int i = 0; i < 16; i++) begin
			apb(0, `SWS_A_RSP_DATA, 0);
			rsp[i] = rd[7:0];
		end
		chk("status result", st[15:8], r);
		chk("status length", st[23:16], l);
		chk("length byte", rsp[0], l);
		chk("result byte", rsp[1], r);
	endtask
	function automatic logic [15:0] crc(input logic [7:0] b[$]);
		logic [15:0] c;
		c = `SWS_CRC_INIT;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = ((c[0] ^ b[i][k]) ? (c >> 1) ^ `SWS_CRC_POLY : c >> 1);
		return c;
	endfunction
	task t_block;
		sws_line_model_inst.lag = 0;
		sws_line_model_inst.rd_q = {8'h12, 8'h34, 8'hFE};
		q = {`SWS_BR_REQ_LEN, 8'h03};
		run(`SWS_CMD_BLOCK_READ, `SWS_RES_OK, 8'h04);
		chk("fetch 0", rsp[2], 8'h12);
		chk("fetch 1", rsp[3], 8'h34);
		chk("fetch 2", rsp[4], 8'hFE);
		q = {`SWS_BR_REQ_LEN, 8'h7F};
		run(`SWS_CMD_BLOCK_READ, `SWS_RES_BAD_PARAM, 8'h01);
		sws_line_model_inst.flt = 1;
		q = {`SWS_BR_REQ_LEN, 8'h02};
		run(`SWS_CMD_BLOCK_READ, `SWS_RES_BR_COMM, 8'h01);
		sws_line_model_inst.flt = 0;
		$display("test block read done");
	endtask
	task t_search;
		sws_line_model_inst.lag = 3;
		sws_line_model_inst.node_id = ID;
		sws_line_model_inst.wr_q.delete();
		q = {`SWS_SR_REQ_LEN, 8'h05, 8'hF0};
		run(`SWS_CMD_SEARCH, `SWS_RES_OK, 8'h0A);
		for (int k = 0; k < 8; k++)
			chk("identity", rsp[2 + k], ID[8 * k +: 8]);
		chk("final flag", rsp[10], 8'h01);
		chk("search code", sws_line_model_inst.wr_q[0], 8'hF0);
		// next search follows with nothing between
		q = {`SWS_SR_REQ_LEN, 8'h00, 8'hF0};
		run(`SWS_CMD_SEARCH, `SWS_RES_NOT_FOUND, 8'h01);
		sws_line_model_inst.pres = 0;
		q = {`SWS_SR_REQ_LEN, 8'h05, 8'hF0};
		run(`SWS_CMD_SEARCH, `SWS_RES_NO_PRESENCE, 8'h01);
		q = {`SWS_SR_REQ_LEN, 8'h07, 8'hF0};
		run(`SWS_CMD_SEARCH, `SWS_RES_OK, 8'h0A);
		chk("identity again", rsp[2], ID[7:0]);
		sws_line_model_inst.pres = 1;
		q = {`SWS_SR_REQ_LEN, 8'h0C, 8'hF0};
		run(`SWS_CMD_SEARCH, `SWS_RES_BAD_PARAM, 8'h01);
		$display("test search done");
	endtask
	task t_full(input logic [7:0] u, input logic bad);
		logic [15:0] c1, c2;
		logic [7:0] t[$];
		t = {`SWS_CMD_START, 8'h02, 8'h3C, 8'hC3};
		c1 = ~crc(t);
		t = {8'h01, 8'h5E};
		c2 = ~crc(t);
		sws_line_model_inst.rd_q = {c1[7:0] ^ {7'h0, bad}, c1[15:8],
			8'h00, 8'h01, 8'h5E, c2[7:0], c2[15:8]};
		sws_line_model_inst.wr_q.delete();
		sws_line_model_inst.spu_cnt = 0;
		q = {8'h0B, u};
		for (int k = 0; k < 8; k++)
			q.push_back(ID[8 * k +: 8]);
		q = {q, 8'h3C, 8'hC3};
		if (bad) begin
			run(`SWS_CMD_FULL_SEQ, `SWS_RES_FS_COMM, 8'h01);
			chk("no release", sws_line_model_inst.wr_q.size(), 13);
		end else begin
			run(`SWS_CMD_FULL_SEQ, `SWS_RES_OK, 8'h03);
			chk("reply length", rsp[2], 8'h01);
			chk("reply byte", rsp[3], 8'h5E);
			chk("writes", sws_line_model_inst.wr_q.size(), 14);
			chk("select", sws_line_model_inst.wr_q[0], 8'h55);
			chk("id first", sws_line_model_inst.wr_q[1], ID[7:0]);
			chk("start", sws_line_model_inst.wr_q[9], 8'h66);
			chk("plen", sws_line_model_inst.wr_q[10], 8'h02);
			chk("release", sws_line_model_inst.wr_q[13], 8'hAA);
			chk("hold", sws_line_model_inst.spu_cnt >= u * HS &&
				sws_line_model_inst.spu_cnt <= u * HS + 8, 1);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1;
		apb(0, `SWS_A_CONFIG, 0);
		chk("config reset", rd, {30'h0, `SWS_CFG_RESET});
		apb(0, 8'h40, 0);
		chk("unmapped error", err, 1'b1);
		chk("unmapped data", rd, 0);
		t_block;
		t_search;
		t_full(8'h01, 0);
		t_full(8'h02, 1);
		apb(1, `SWS_A_CONFIG, 0);
		q = {8'h01, 8'h00};
		run(`SWS_CMD_FULL_SEQ, `SWS_RES_FS_DISABLED, 8'h01);
		run(8'h99, `SWS_RES_BAD_PARAM, 8'h01);
		apb(1, `SWS_A_CONFIG, 3);
		// Config lands at the access edge, look one edge later
		@(posedge clk);
		chk("overdrive", ovd, 1'b1);
		q = {`SWS_FS_HDR_LEN, 8'h00};
		run(`SWS_CMD_FULL_SEQ, `SWS_RES_FS_SEQ, 8'h01);
		t_full(8'h01, 0);
		$display("test full sequence done");
		give_verdict;
	end
endmodule
